// ==== pce_regs.svh ====
// Register offsets, reset values and field positions of the pin change interrupt block
//
// Summary of operation
// - A flag cleared by software stays set if an enabled edge arrives then.
// - A pin change wakes the core from sleep when the master enable is set.
// - Edges seen during sleep are in the flags before the first instruction runs.
// - Eight-bit rising edge enable register, one bit per pin.
// - Eight-bit falling edge enable register, one bit per pin.
// - Flag sets on an enabled rising or falling edge, stays until cleared.
// - Flag reads zero until an enabled edge, or after software writes zero.
// - Detection and flags keep working while the master enable is clear.
// - Summary flag is the OR of all eight pin flags.
// - Both enables set means both directions are detected.
`ifndef PCE_REGS_SVH
`define PCE_REGS_SVH

`define PCE_ADDR_W        4
`define PCE_OFS_RISE      4'h0
`define PCE_OFS_FALL      4'h1
`define PCE_OFS_FLAGS     4'h2
`define PCE_OFS_CTRL      4'h3
`define PCE_OFS_IRQ_STAT  4'h4
`define PCE_OFS_IRQ_MASK  4'h5
`define PCE_RST_BYTE      8'h00
`define PCE_CTRL_MIE_BIT  0
`define PCE_CTRL_SUM_BIT  1

`endif

// ==== pce_pkg.sv ====
// Types shared by the pin change interrupt block
package pce_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pce_bus_req_t;

endpackage

// ==== pce_top.sv ====
// Pin change edge detector with flags, summary interrupt and sleep wake
`timescale 1ns/10ps
`default_nettype none
`include "pce_regs.svh"

module pce_top
  import pce_pkg::*;
#(
  parameter int NPINS = 8
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [NPINS-1:0] port_pin_n,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  output logic                  irq,
  output logic                  wake
);

  pce_bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detect
  logic [NPINS-1:0] sync1_r;
  logic [NPINS-1:0] sync2_r;
  logic [NPINS-1:0] prev_r;
  logic [NPINS-1:0] rise_ev;
  logic [NPINS-1:0] fall_ev;
  logic [NPINS-1:0] edge_ev;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end
    else
    begin
      sync1_r <= port_pin_n;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [NPINS-1:0] rise_en_r;
  logic [NPINS-1:0] rise_en_nxt;
  logic [NPINS-1:0] fall_en_r;
  logic [NPINS-1:0] fall_en_nxt;
  logic [NPINS-1:0] flags_r;
  logic [NPINS-1:0] flags_nxt;
  logic             mie_r;
  logic             mie_nxt;
  logic [NPINS-1:0] istat_r;
  logic [NPINS-1:0] istat_nxt;
  logic [NPINS-1:0] imask_r;
  logic [NPINS-1:0] imask_nxt;
  logic [7:0]       rdata_nxt;
  logic             irq_nxt;
  logic             wake_nxt;
  logic             summary;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++)
    begin : g_pin
      // Rising and falling enables are independent, both may be set
      assign rise_ev[gi] = rise_en_r[gi] & sync2_r[gi] & ~prev_r[gi];
      assign fall_ev[gi] = fall_en_r[gi] & ~sync2_r[gi] & prev_r[gi];
      assign edge_ev[gi] = rise_ev[gi] | fall_ev[gi];
    end
  endgenerate

  assign summary = |flags_r;

  always_comb
  begin
    rise_en_nxt = rise_en_r;
    fall_en_nxt = fall_en_r;
    flags_nxt   = flags_r;
    mie_nxt     = mie_r;
    istat_nxt   = istat_r;
    imask_nxt   = imask_r;
    rdata_nxt   = 8'h00;
    if (req.wr)
    begin
      if (req.addr == `PCE_OFS_RISE)
        rise_en_nxt = req.wdata[NPINS-1:0];
      else if (req.addr == `PCE_OFS_FALL)
        fall_en_nxt = req.wdata[NPINS-1:0];
      else if (req.addr == `PCE_OFS_FLAGS)
        flags_nxt = flags_r & req.wdata[NPINS-1:0];
      else if (req.addr == `PCE_OFS_CTRL)
        mie_nxt = req.wdata[`PCE_CTRL_MIE_BIT];
      else if (req.addr == `PCE_OFS_IRQ_MASK)
        imask_nxt = req.wdata[NPINS-1:0];
    end
    if (req.rd)
    begin
      if (req.addr == `PCE_OFS_RISE)
        rdata_nxt = 8'(rise_en_r);
      else if (req.addr == `PCE_OFS_FALL)
        rdata_nxt = 8'(fall_en_r);
      else if (req.addr == `PCE_OFS_FLAGS)
        rdata_nxt = 8'(flags_r);
      else if (req.addr == `PCE_OFS_CTRL)
      begin
        rdata_nxt[`PCE_CTRL_MIE_BIT] = mie_r;
        rdata_nxt[`PCE_CTRL_SUM_BIT] = summary;
      end
      else if (req.addr == `PCE_OFS_IRQ_STAT)
      begin
        rdata_nxt = 8'(istat_r);
        istat_nxt = '0;
      end
      else if (req.addr == `PCE_OFS_IRQ_MASK)
        rdata_nxt = 8'(imask_r);
    end
    // Edges win over a software clear; detection ignores the master enable
    flags_nxt = flags_nxt | edge_ev;
    istat_nxt = istat_nxt | edge_ev;
    irq_nxt   = mie_nxt & (|(istat_nxt & imask_nxt));
    // Wake runs without the core clock gated here, so sleep edges land in flags
    wake_nxt  = mie_nxt & (|flags_nxt);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_en_r <= `PCE_RST_BYTE;
      fall_en_r <= `PCE_RST_BYTE;
      flags_r   <= `PCE_RST_BYTE;
      mie_r     <= 1'b0;
      istat_r   <= `PCE_RST_BYTE;
      imask_r   <= `PCE_RST_BYTE;
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
      wake      <= 1'b0;
    end
    else
    begin
      rise_en_r <= rise_en_nxt;
      fall_en_r <= fall_en_nxt;
      flags_r   <= flags_nxt;
      mie_r     <= mie_nxt;
      istat_r   <= istat_nxt;
      imask_r   <= imask_nxt;
      reg_rdata <= rdata_nxt;
      irq       <= irq_nxt;
      wake      <= wake_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_edge_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|edge_ev) |=> ((flags_r & $past(edge_ev)) == $past(edge_ev)))
    else $error("edge did not set flag");

  chk_rise_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync2_r[0] && !prev_r[0] && rise_en_r[0]) |=> flags_r[0])
    else $error("rising edge missed");

  chk_fall_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!sync2_r[0] && prev_r[0] && fall_en_r[0]) |=> flags_r[0])
    else $error("falling edge missed");

  chk_no_spurious: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!flags_r[0] && !edge_ev[0]) |=> !flags_r[0])
    else $error("flag set without edge");

  chk_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.wr && req.addr == `PCE_OFS_FLAGS && !req.wdata[0] && !edge_ev[0])
      |=> !flags_r[0])
    else $error("flag clear ignored");

  chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (flags_r[0] && !(req.wr && req.addr == `PCE_OFS_FLAGS)) |=> flags_r[0])
    else $error("flag dropped");

  chk_wake_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mie_r && summary && !(req.wr && (req.addr == `PCE_OFS_FLAGS || req.addr == `PCE_OFS_CTRL)))
      |=> wake)
    else $error("wake missing");

  chk_no_wake_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !mie_r |=> !wake || $past(mie_nxt))
    else $error("wake without enable");

  chk_both_dirs: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rise_en_r[1] && fall_en_r[1] && (sync2_r[1] != prev_r[1])) |=> flags_r[1])
    else $error("both-edge mode missed");

  chk_sync_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 prev_r == $past(sync2_r))
    else $error("edge sample chain broken");

  chk_summary_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.rd && req.addr == `PCE_OFS_CTRL) |=> reg_rdata[`PCE_CTRL_SUM_BIT] == |$past(flags_r))
    else $error("summary flag wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Collision, master enable and register path checks
  // Sticky and gating antecedents skip cycles where software rewrites the state under test; collision and write checks drive that write

  chk_clear_collide: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.wr && req.addr == `PCE_OFS_FLAGS && edge_ev[0])
      |=> flags_r[0])
    else $error("edge lost under clear");

  chk_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!mie_r && !(req.wr && req.addr == `PCE_OFS_CTRL))
      |=> !irq)
    else $error("irq without master enable");

  chk_flag_no_mie: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!mie_r && edge_ev[2])
      |=> flags_r[2])
    else $error("flag lost with master enable off");

  chk_both_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!rise_en_r[0] && !fall_en_r[0])
      |-> !edge_ev[0])
    else $error("edge on disabled pin");

  chk_fall_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !fall_en_r[3]
      |-> !fall_ev[3])
    else $error("falling edge while disabled");

  chk_rise_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rise_en_r[3]
      |-> !rise_ev[3])
    else $error("rising edge while disabled");

  chk_stat_clear_rd: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.rd && req.addr == `PCE_OFS_IRQ_STAT && !edge_ev[0])
      |=> !istat_r[0])
    else $error("status not cleared by read");

  chk_stat_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (istat_r[0] && !(req.rd && req.addr == `PCE_OFS_IRQ_STAT))
      |=> istat_r[0])
    else $error("status bit dropped");

  chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !req.rd
      |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");

  chk_rd_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.rd && req.addr == `PCE_OFS_FLAGS)
      |=> reg_rdata[NPINS-1:0] == $past(flags_r))
    else $error("flag read wrong");

  chk_flag_no_set_wr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.wr && req.addr == `PCE_OFS_FLAGS && !flags_r[1] && !edge_ev[1])
      |=> !flags_r[1])
    else $error("flag set by write");

  chk_wake_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!summary && !(|edge_ev))
      |=> !wake)
    else $error("wake without flag");

  chk_sleep_record: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((|edge_ev) && mie_r && !(req.wr && req.addr == `PCE_OFS_CTRL))
      |=> (wake && summary))
    else $error("wake before flag recorded");

  chk_rd_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.rd && req.addr == `PCE_OFS_RISE)
      |=> reg_rdata[NPINS-1:0] == $past(rise_en_r))
    else $error("rise enable read wrong");

  chk_rd_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.rd && req.addr == `PCE_OFS_FALL)
      |=> reg_rdata[NPINS-1:0] == $past(fall_en_r))
    else $error("fall enable read wrong");

  chk_wr_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.wr && req.addr == `PCE_OFS_RISE)
      |=> rise_en_r == $past(req.wdata[NPINS-1:0]))
    else $error("rise enable write lost");

  chk_wr_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.wr && req.addr == `PCE_OFS_FALL)
      |=> fall_en_r == $past(req.wdata[NPINS-1:0]))
    else $error("fall enable write lost");

  chk_both_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rise_en_r[2] && fall_en_r[2] && !sync2_r[2] && prev_r[2])
      |=> flags_r[2])
    else $error("both-edge falling missed");

  chk_ctrl_mie: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.wr && req.addr == `PCE_OFS_CTRL)
      |=> mie_r == $past(req.wdata[0]))
    else $error("master enable write lost");

endmodule
`default_nettype wire

// ==== pce_pin_model.sv ====
// Stand-in for the eight external port pins
`timescale 1ns/10ps
`default_nettype none
module pce_pin_model
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] pin_tgt,
  output var  logic [7:0] port_pin_n
);
  // Pins move just after an edge, the worst case for the synchroniser
  // Unknown only until the first edge, which falls inside reset
  always @(posedge ref_clk) port_pin_n <= pin_tgt;
endmodule
`default_nettype wire

// ==== tb_pin_change_edge_interrupt.sv ====
// Self-checking bench for the pin change edge interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "pce_regs.svh"
module tb_pin_change_edge_interrupt;
  logic       ref_clk, rst_n, reg_wr, reg_rd, irq, wake, mie;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, port_pin_n, pin_tgt;
  logic [7:0] flg, stat, r, f, m, ex, kw;
  int         n_mismatch, num_checks;

  pce_pin_model PM (.ref_clk(ref_clk), .pin_tgt(pin_tgt), .port_pin_n(port_pin_n));
  pce_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .port_pin_n(port_pin_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .wake(wake));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] det(logic [7:0] o, logic [7:0] n);
    return (r & ~o & n) | (f & o & ~n);
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Six edges cover two sync flops, the compare and the registered outputs
  task automatic pins(logic [7:0] v);
    @(posedge ref_clk);
    ex = det(port_pin_n, v);
    pin_tgt <= v;
    repeat (6) @(posedge ref_clk);
    flg |= ex;
    stat |= ex;
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, pin_tgt} = '0;
    {flg, stat, r, f} = '0;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'h839c));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`PCE_OFS_RISE, 8'h00);
    rd(`PCE_OFS_FALL, 8'h00);
    rd(`PCE_OFS_FLAGS, 8'h00);
    rd(4'hf, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      r = (i < 2) ? 8'hff : 8'($urandom);
      f = (i < 2) ? 8'hff : 8'($urandom);
      m = 8'($urandom);
      mie = 1'($urandom);
      wr(`PCE_OFS_RISE, r);
      wr(`PCE_OFS_FALL, f);
      wr(`PCE_OFS_CTRL, {7'h00, mie});
      wr(`PCE_OFS_IRQ_MASK, m);
      rd(`PCE_OFS_RISE, r);
      rd(`PCE_OFS_FALL, f);
      pins((i < 2) ? ~port_pin_n : 8'($urandom));
      rd(`PCE_OFS_FLAGS, flg);
      rd(`PCE_OFS_CTRL, {6'h00, |flg, mie});
      chk({6'h00, irq, wake}, {6'h00, mie & |(stat & m), mie & |flg});
      rd(`PCE_OFS_IRQ_STAT, stat);
      stat = 8'h00;
      rd(`PCE_OFS_IRQ_STAT, 8'h00);
      chk({7'h00, irq}, 8'h00);
      // AND-style clear of known bits only, so no fresh edge is lost
      kw = flg & 8'($urandom);
      wr(`PCE_OFS_FLAGS, ~kw);
      flg &= ~kw;
      rd(`PCE_OFS_FLAGS, flg);
    end
    r = 8'hff;
    f = 8'h00;
    wr(`PCE_OFS_RISE, r);
    wr(`PCE_OFS_FALL, f);
    pins(8'h00);
    wr(`PCE_OFS_FLAGS, 8'h00);
    // Rising edges on all pins land on the very edge that takes the clear
    @(posedge ref_clk);
    pin_tgt <= 8'hff;
    repeat (2) @(posedge ref_clk);
    wr(`PCE_OFS_FLAGS, 8'h00);
    rd(`PCE_OFS_FLAGS, 8'hff);
    complete_run();
  end
endmodule
`default_nettype wire
